/* core/dspi_top.sv */
// Operation
// - boot mode pin picks serial port or spi
// - two select inputs, fourteen select outputs
// - select pins borrowed from programmable flag pins
// - full duplex, master or slave, multimaster safe
// - rate, polarity set independently; phase used in slave mode only
// - sck equals clock over twice divisor
// - dma carries one direction at once
// - shift out and in together
// - master drives clock pulses, mosi out, miso in
// - master dma receive stops when count hits zero
// - descriptors come from io page zero
// - buffer access starts non-dma master transfer
// - slave samples only while selected
// - slave receive descriptor may raise interrupt
// - slave dma runs to zero, accepts next
// - slave sends zeros when nothing ready
`timescale 1ns/1ps
`include "dspi_consts.svh"
module dspi_top
   import dspi_pkg::*;
(
   input  wire logic                       sys_clk_i,
   input  wire logic                       nrst_i,
   input  wire logic                       boot_op_mode_pin_i,
   input  wire dspi_cfg_t [1:0]            cfg_i,
   input  wire logic [1:0][6:0]            device_select_i,
   input  wire logic [1:0]                 desc_valid_i,
   input  wire dspi_desc_t [1:0]           desc_i,
   input  wire logic [15:0]                desc_page_i,
   input  wire logic [1:0][15:0]           tx_data_i,
   input  wire logic [1:0]                 tx_valid_i,
   output logic [1:0]                      tx_ready_o,
   input  wire logic [1:0]                 rx_read_i,
   output logic [1:0][15:0]                rx_data_o,
   output logic [1:0]                      rx_valid_o,
   input  wire logic [1:0]                 slave_select_input_n_i,
   input  wire logic [1:0]                 sck_i,
   input  wire logic [1:0]                 mosi_i,
   input  wire logic [1:0]                 miso_i,
   output logic [1:0]                      sck_o,
   output logic [1:0]                      sck_oe_o,
   output logic [1:0]                      mosi_o,
   output logic [1:0]                      mosi_oe_o,
   output logic [1:0]                      miso_o,
   output logic [1:0]                      miso_oe_o,
   output logic [13:0]                     device_select_outputs_n_o,
   output logic                            spi_active_o,
   output logic [1:0]                      desc_ready_o,
   output logic [1:0]                      done_irq_o,
   output logic [1:0]                      busy_o
);
   logic       mode_q;
   logic       seen_q;
   logic [1:0] page_ok;

   // strap caught on the first clock after reset release, then held
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mode_q <= 1'b0;
         seen_q <= 1'b0;
      end
      else if (!seen_q)
      begin
         mode_q <= boot_op_mode_pin_i;
         seen_q <= 1'b1;
      end
   end

   assign spi_active_o = mode_q;
   // only descriptors from io page zero are taken
   assign page_ok = {2{desc_page_i == 16'h0000}};

   genvar p;
   generate
      for (p = 0; p < `DSPI_NPORT; p++)
      begin : g_port
         dspi_state_t st_q;
         logic [15:0] div_q;
         logic [4:0]  bit_q;
         logic [15:0] sh_q;
         logic [15:0] cnt_q;
         logic        irq_en_q;
         logic        sck_q;
         logic        sck_d1_q;
         logic        ss_n_q;
         logic        run;
         logic        on;
         logic        lead_edge;
         logic        trail_edge;
         logic [4:0]  nbits;
         logic        f_ready;
         logic [15:0] f_data;
         logic        f_valid;
         logic        rx_push;
         logic [15:0] rx_word;
         logic        rx_fready;
         logic        tx_take;
         logic        sdi;
         logic [15:0] rx_shift;
         logic        smp_edge;
         logic        shf_edge;

         assign on    = mode_q && cfg_i[p].enable;
         assign nbits = cfg_i[p].size16 ? 5'd16 : 5'd8;
         assign sdi   = cfg_i[p].master ? miso_i[p] : mosi_i[p];
         // 8-bit words live in the low byte of the shifter
         // master's last bit is still on the pin when the word is pushed
         assign rx_shift = cfg_i[p].master ? {sh_q[14:0], sdi} : sh_q;
         assign rx_word  = cfg_i[p].size16 ? rx_shift
                           : {8'h00, rx_shift[7:0]};

         // transmit words queue in front of the shifter
         dspi_fifo #(.WIDTH(`DSPI_DW), .DEPTH(`DSPI_FIFO_DEPTH)) u_txf
         (
            .sys_clk_i   (sys_clk_i),
            .nrst_i      (nrst_i),
            .in_data_i   (tx_data_i[p]),
            .in_valid_i  (tx_valid_i[p] && !(cfg_i[p].dma_en
                          && cfg_i[p].dma_rx)),
            .in_ready_o  (f_ready),
            .out_data_o  (f_data),
            .out_valid_o (f_valid),
            .out_ready_i (tx_take)
         );

         // master starts on a queued word, a core receive read, or a nonzero dma receive count
         assign run = cfg_i[p].master && (f_valid || (!cfg_i[p].dma_en
                      && rx_read_i[p]) || (cfg_i[p].dma_en
                      && cfg_i[p].dma_rx && cnt_q != 16'h0000));
         assign tx_take = (st_q == DSPI_IDLE) && f_valid && on
                          && (cfg_i[p].master ? 1'b1 : !ss_n_q);

         // slave edge detect on the sampled external clock
         always_ff @(posedge sys_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               sck_d1_q <= 1'b0;
               ss_n_q   <= 1'b1;
            end
            else
            begin
               sck_d1_q <= sck_i[p];
               ss_n_q   <= slave_select_input_n_i[p];
            end
         end
         assign lead_edge  = (sck_i[p] != sck_d1_q)
                             && (sck_i[p] != cfg_i[p].cpol);
         assign trail_edge = (sck_i[p] != sck_d1_q)
                             && (sck_i[p] == cfg_i[p].cpol);
         // phase swaps which edge samples; no edge means no event
         assign smp_edge   = cfg_i[p].cpha ? trail_edge : lead_edge;
         assign shf_edge   = cfg_i[p].cpha ? lead_edge : trail_edge;

         // shift engine: master toggles sck every baud count
         always_ff @(posedge sys_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               st_q  <= DSPI_IDLE;
               div_q <= 16'h0000;
               bit_q <= 5'd0;
               sh_q  <= 16'h0000;
               sck_q <= 1'b0;
            end
            else if (!on)
            begin
               st_q  <= DSPI_IDLE;
               sck_q <= cfg_i[p].cpol;
            end
            else if (cfg_i[p].master)
            begin
               case (st_q)
                  DSPI_IDLE:
                  begin
                     sck_q <= cfg_i[p].cpol;
                     if (run && rx_fready)
                     begin
                        sh_q  <= tx_take ? f_data : 16'h0000;
                        bit_q <= 5'd0;
                        div_q <= 16'h0000;
                        st_q  <= DSPI_LEAD;
                     end
                  end
                  DSPI_LEAD, DSPI_TRAIL:
                  begin
                     // half period is baud clocks: sck = clk/(2*baud)
                     if (div_q + 16'h0001 >= cfg_i[p].baud)
                     begin
                        div_q <= 16'h0000;
                        sck_q <= ~sck_q;
                        if (st_q == DSPI_LEAD)
                           st_q <= DSPI_TRAIL;
                        else
                        begin
                           // sample while sck_o still shows the lead
                           // level; shifting here keeps mosi steady
                           // across the far side's sampling edge
                           sh_q <= {sh_q[14:0], sdi};
                           if (bit_q + 5'd1 == nbits)
                              st_q <= DSPI_IDLE;
                           else
                           begin
                              bit_q <= bit_q + 5'd1;
                              st_q  <= DSPI_LEAD;
                           end
                        end
                     end
                     else
                        div_q <= div_q + 16'h0001;
                  end
                  default: st_q <= DSPI_IDLE;
               endcase
            end
            else
            begin
               // slave: nothing moves while deselected
               if (ss_n_q)
               begin
                  st_q  <= DSPI_IDLE;
                  bit_q <= 5'd0;
               end
               else
               begin
                  case (st_q)
                     DSPI_IDLE:
                     begin
                        // empty queue sends a zero word
                        sh_q  <= tx_take ? f_data : 16'h0000;
                        bit_q <= 5'd0;
                        st_q  <= DSPI_LEAD;
                     end
                     DSPI_LEAD:
                        if (smp_edge)
                        begin
                           sh_q <= {sh_q[14:0], sdi};
                           st_q <= DSPI_TRAIL;
                        end
                     DSPI_TRAIL:
                        if (shf_edge)
                           st_q <= (bit_q + 5'd1 == nbits) ? DSPI_IDLE
                                   : DSPI_LEAD;
                     default: st_q <= DSPI_IDLE;
                  endcase
                  if (st_q == DSPI_TRAIL && shf_edge)
                     bit_q <= bit_q + 5'd1;
               end
            end
         end

         // word ends on the edge that samples its last bit (master) or on the next shift edge (slave)
         assign rx_push = on && st_q == DSPI_TRAIL && bit_q + 5'd1 == nbits
                          && (cfg_i[p].master
                              ? div_q + 16'h0001 >= cfg_i[p].baud
                              : (!ss_n_q && shf_edge));

         // received words queue toward the core or the dma engine
         dspi_fifo #(.WIDTH(`DSPI_DW), .DEPTH(`DSPI_FIFO_DEPTH)) u_rxf
         (
            .sys_clk_i   (sys_clk_i),
            .nrst_i      (nrst_i),
            .in_data_i   (rx_word),
            .in_valid_i  (rx_push),
            .in_ready_o  (rx_fready),
            .out_data_o  (rx_data_o[p]),
            .out_valid_o (rx_valid_o[p]),
            .out_ready_i (rx_read_i[p])
         );

         // dma word count, descriptor accepted only when the count is zero
         always_ff @(posedge sys_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               cnt_q      <= 16'h0000;
               irq_en_q   <= 1'b0;
               done_irq_o[p] <= 1'b0;
            end
            else
            begin
               done_irq_o[p] <= 1'b0;
               if (desc_valid_i[p] && page_ok[p] && cnt_q == 16'h0000)
               begin
                  cnt_q    <= desc_i[p].count;
                  irq_en_q <= desc_i[p].irq_en;
               end
               else if (cfg_i[p].dma_en && rx_push && cnt_q != 16'h0000)
               begin
                  cnt_q <= cnt_q - 16'h0001;
                  if (cnt_q == 16'h0001)
                     done_irq_o[p] <= irq_en_q;
               end
            end
         end

         // registered pin and status outputs
         always_ff @(posedge sys_clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               sck_o[p]     <= 1'b0;
               sck_oe_o[p]  <= 1'b0;
               mosi_o[p]    <= 1'b0;
               mosi_oe_o[p] <= 1'b0;
               miso_o[p]    <= 1'b0;
               miso_oe_o[p] <= 1'b0;
               tx_ready_o[p]   <= 1'b0;
               desc_ready_o[p] <= 1'b0;
               busy_o[p]       <= 1'b0;
            end
            else
            begin
               // master drives only while enabled, so masters can share
               sck_o[p]     <= sck_q;
               sck_oe_o[p]  <= on && cfg_i[p].master;
               mosi_o[p]    <= cfg_i[p].size16 ? sh_q[15] : sh_q[7];
               mosi_oe_o[p] <= on && cfg_i[p].master;
               miso_o[p]    <= cfg_i[p].size16 ? sh_q[15] : sh_q[7];
               miso_oe_o[p] <= on && !cfg_i[p].master && !ss_n_q;
               tx_ready_o[p]   <= f_ready;
               desc_ready_o[p] <= cnt_q == 16'h0000;
               busy_o[p]       <= st_q != DSPI_IDLE;
            end
         end
      end
   endgenerate

   // flag pins carry the active-low selects only in spi mode
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         device_select_outputs_n_o <= 14'h3FFF;
      else if (mode_q)
         device_select_outputs_n_o <= ~{device_select_i[1],
                                        device_select_i[0]};
      else
         device_select_outputs_n_o <= 14'h3FFF;
   end
endmodule

/* shared/dspi_consts.svh */
`ifndef DSPI_CONSTS_SVH
`define DSPI_CONSTS_SVH
`define DSPI_NPORT      2
`define DSPI_NSEL       7
`define DSPI_DW         16
`define DSPI_CNTW       16
`define DSPI_BAUDW      16
`define DSPI_SIZE8      1'b0
`define DSPI_SIZE16     1'b1
`define DSPI_FIFO_DEPTH 8
`define DSPI_CLK_MHZ    125
`endif

/* shared/dspi_pkg.sv */
package dspi_pkg;
   // per-port configuration, static while a transfer runs
   typedef struct packed {
      logic        enable;
      logic        master;
      logic        cpol;
      logic        cpha;
      logic        size16;
      logic        dma_en;
      logic        dma_rx;
      logic [15:0] baud;
   } dspi_cfg_t;
   // descriptor handed to the dma engine
   typedef struct packed {
      logic [15:0] count;
      logic        irq_en;
   } dspi_desc_t;
   typedef enum logic [1:0] {
      DSPI_IDLE,
      DSPI_LEAD,
      DSPI_TRAIL
   } dspi_state_t;
endpackage

/* core/dspi_fifo.sv */
`timescale 1ns/1ps
module dspi_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
)
(
   input  wire logic             sys_clk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // honest full and empty from the fill count
   assign in_ready_o  = cnt_q < (AW+1)'(DEPTH);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // storage has no reset; only pointers and count define state
   always_ff @(posedge sys_clk_i)
   begin
      if (push)
         mem_q[wr_q] <= in_data_i;
   end

   // pointers and count
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* tb/dspi_slave_model.sv */
`timescale 1ns/1ps
module dspi_slave_model
(
   input  wire logic        sck_i,
   input  wire logic        sel_n_i,
   input  wire logic        mosi_i,
   input  wire logic        size16_i,
   input  wire logic [15:0] load_i,
   output logic             miso_o,
   output logic [15:0]      got_o,
   output logic [7:0]       edges_o
);
   logic [15:0] sh;
   initial
   begin
      miso_o = 1'b1;
      got_o = '0;
      edges_o = '0;
      sh = '0;
   end
   // select loads the reply, msb first, low byte for 8-bit words
   always @(negedge sel_n_i)
   begin
      sh = size16_i ? load_i : {load_i[7:0], 8'h00};
      miso_o = sh[15];
      edges_o = '0;
   end
   // mode 0 only: sample on rise, shift on fall
   always @(posedge sck_i)
   begin
      got_o = {got_o[14:0], mosi_i};
      edges_o = edges_o + 8'h01;
   end
   always @(negedge sck_i)
   begin
      sh = sh << 1;
      miso_o = sh[15];
   end
   // released line must not keep its last value
   always @(posedge sel_n_i)
      miso_o = ~miso_o;
endmodule

/* tb/dspi_top_sva.sv */
`timescale 1ns/1ps
module dspi_top_sva
   import dspi_pkg::*;
(
   input wire logic             sys_clk_i,
   input wire logic             nrst_i,
   input wire dspi_cfg_t [1:0]  cfg_i,
   input wire logic [1:0][6:0]  device_select_i,
   input wire logic [1:0]       slave_select_input_n_i,
   input wire logic [1:0]       sck_o,
   input wire logic [1:0]       sck_oe_o,
   input wire logic [1:0]       mosi_oe_o,
   input wire logic [1:0]       miso_oe_o,
   input wire logic [13:0]      device_select_outputs_n_o,
   input wire logic             spi_active_o,
   input wire logic [1:0]       desc_ready_o,
   input wire logic [1:0]       done_irq_o,
   input wire logic [1:0]       busy_o,
   input wire logic [1:0]       rx_valid_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   logic        prev_q;
   logic        seen_q;
   logic [15:0] gap_q;
   // cycles since the last sck edge; first edge of a transfer is skipped
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         prev_q <= 1'b0;
         seen_q <= 1'b0;
         gap_q <= 16'h0000;
      end
      else
      begin
         prev_q <= sck_o[0];
         gap_q <= (sck_o[0] != prev_q) ? 16'h0001 : gap_q + 16'h0001;
         if (sck_o[0] != prev_q)
            seen_q <= busy_o[0];
         else if (!busy_o[0])
            seen_q <= 1'b0;
      end
   end
   a_sck_half_period: assert property ((sck_o[0] != prev_q) && seen_q
      && busy_o[0] && cfg_i[0].master |-> gap_q == cfg_i[0].baud)
      else $error("sck half period differs from divisor");
   a_strap_gates_pins: assert property (!spi_active_o |-> sck_oe_o == 2'h0
      && mosi_oe_o == 2'h0 && miso_oe_o == 2'h0)
      else $error("pins driven while spi inactive");
   a_select_follows: assert property (spi_active_o && $past(spi_active_o) |->
      device_select_outputs_n_o[6:0] == ~$past(device_select_i[0]))
      else $error("select outputs do not follow request");
   a_master_drives: assert property (cfg_i[0].master && busy_o[0]
      && $past(busy_o[0]) |-> sck_oe_o[0] && mosi_oe_o[0])
      else $error("master not driving sck and mosi");
   a_sck_idle_still: assert property (cfg_i[0].master && !busy_o[0]
      && !$past(busy_o[0]) && !$past(busy_o[0], 2) |-> $stable(sck_o[0]))
      else $error("sck moved outside a transfer");
   a_slave_quiet: assert property ((cfg_i[1].enable && !cfg_i[1].master
      && slave_select_input_n_i[1]) [*4] |-> !miso_oe_o[1])
      else $error("unselected slave drives miso");
   a_irq_single: assert property (done_irq_o[0] |=> !done_irq_o[0])
      else $error("done pulse longer than one cycle");
   a_irq_ready: assert property (done_irq_o[0] |-> ##[0:2] desc_ready_o[0])
      else $error("engine not ready after count end");
   c_irq: cover property (done_irq_o[0]);
   c_slave_word: cover property ($rose(rx_valid_o[1]));
   c_select: cover property ($fell(device_select_outputs_n_o[0]));
endmodule
bind dspi_top dspi_top_sva u_dspi_top_sva (.sys_clk_i(sys_clk_i),
   .nrst_i(nrst_i), .cfg_i(cfg_i), .device_select_i(device_select_i),
   .slave_select_input_n_i(slave_select_input_n_i), .sck_o(sck_o),
   .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o),
   .device_select_outputs_n_o(device_select_outputs_n_o),
   .spi_active_o(spi_active_o), .desc_ready_o(desc_ready_o),
   .done_irq_o(done_irq_o), .busy_o(busy_o), .rx_valid_o(rx_valid_o));

/* tb/dspi_top_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("unexpected %s exp %0h got %0h", n, e, g); end end
module dspi_top_tb_top;
   import dspi_pkg::*;
   logic             sys_clk_i = 1'b0;
   logic             nrst_i = 1'b0;
   logic             strap = 1'b1;
   dspi_cfg_t [1:0]  cfg = '0;
   dspi_desc_t [1:0] desc = '0;
   logic [1:0][6:0]  dsel = '0;
   logic [1:0][15:0] txd = '0;
   logic [1:0][15:0] rx_data;
   logic [15:0]      page = '0, pload = '0, pgot;
   logic [1:0]       dv = '0, txv = '0, rxr = '0, ssn = 2'h3, scki = '0;
   logic [1:0]       mosii = '0, tx_ready, rx_valid, sck, mosi, miso;
   logic [1:0]       desc_ready, done_irq, busy;
   logic [13:0]      dso_n;
   logic [7:0]       pedges;
   logic             act, pmiso;
   int               comparisons = 0, fails = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   dspi_top u_dspi_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .boot_op_mode_pin_i(strap), .cfg_i(cfg), .device_select_i(dsel),
      .desc_valid_i(dv), .desc_i(desc), .desc_page_i(page), .tx_data_i(txd),
      .tx_valid_i(txv), .tx_ready_o(tx_ready), .rx_read_i(rxr),
      .rx_data_o(rx_data), .rx_valid_o(rx_valid),
      .slave_select_input_n_i(ssn), .sck_i(scki), .mosi_i(mosii),
      .miso_i({1'b0, pmiso}), .sck_o(sck), .sck_oe_o(), .mosi_o(mosi),
      .mosi_oe_o(), .miso_o(miso), .miso_oe_o(),
      .device_select_outputs_n_o(dso_n), .spi_active_o(act),
      .desc_ready_o(desc_ready), .done_irq_o(done_irq), .busy_o(busy));
   dspi_slave_model u_dspi_slave_model (.sck_i(sck[0]), .sel_n_i(dso_n[0]),
      .mosi_i(mosi[0]), .size16_i(cfg[0].size16), .load_i(pload),
      .miso_o(pmiso), .got_o(pgot), .edges_o(pedges));
   function automatic dspi_cfg_t mk(logic m, logic s, logic d, logic r,
                                    logic [15:0] b);
      mk = '{enable:1'b1, master:m, cpol:1'b0, cpha:1'b0, size16:s,
             dma_en:d, dma_rx:r, baud:b};
   endfunction
   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         fails++;
         $display("unexpected wait exp done got timeout");
         report_and_stop;
      end
   endtask
   task automatic do_reset(input logic s);
      nrst_i <= 1'b0;
      strap <= s;
      cfg <= '0;
      dsel <= '0;
      repeat (20) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
   endtask
   // strap low must keep the ports dead even when asked to run
   task automatic t_strap;
      do_reset(1'b0);
      cfg[0] <= mk(1'b1, 1'b0, 1'b0, 1'b0, 16'h0001);
      dsel[0] <= 7'h01;
      txd[0] <= 16'h005A;
      txv[0] <= 1'b1;
      repeat (40) @(posedge sys_clk_i);
      txv[0] <= 1'b0;
      `CHK("active", 1'b0, act)
      `CHK("busy", 1'b0, busy[0])
      do_reset(1'b1);
      `CHK("active", 1'b1, act)
      $display("test strap done");
   endtask
   // configure, select, then push one word; partner answers
   task automatic t_master(input logic s16, input logic [15:0] baud,
                           input logic [15:0] tx, input logic [15:0] rx);
      int          n;
      logic [15:0] m;
      m = s16 ? 16'hFFFF : 16'h00FF;
      cfg[0] <= mk(1'b1, s16, 1'b0, 1'b0, baud);
      pload <= rx;
      @(posedge sys_clk_i);
      dsel[0] <= 7'h01;
      repeat (2) @(posedge sys_clk_i);
      `CHK("sel_n", 1'b0, dso_n[0])
      txd[0] <= tx;
      txv[0] <= 1'b1;
      n = 0;
      do begin @(posedge sys_clk_i); n++; end
      while (tx_ready[0] !== 1'b1 && n < 50);
      txv[0] <= 1'b0;
      bound(n, 50);
      n = 0;
      while (rx_valid[0] !== 1'b1 && n < 2000)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      bound(n, 2000);
      `CHK("rx", rx & m, rx_data[0] & m)
      `CHK("mosi", tx & m, pgot & m)
      `CHK("edges", s16 ? 8'h10 : 8'h08, pedges)
      rxr[0] <= 1'b1;
      @(posedge sys_clk_i);
      rxr[0] <= 1'b0;
      // that read starts one more transfer; its word must arrive
      n = 0;
      while (rx_valid[0] !== 1'b1 && n < 2000)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      bound(n, 2000);
      `CHK("read_start", 1'b1, rx_valid[0])
      // pop with the port off so no further transfer starts
      cfg[0].enable <= 1'b0;
      rxr[0] <= 1'b1;
      @(posedge sys_clk_i);
      rxr[0] <= 1'b0;
      dsel[0] <= '0;
      repeat (2) @(posedge sys_clk_i);
      `CHK("rx_empty", 1'b0, rx_valid[0])
      $display("test master done");
   endtask
   // bad page refused, then two receive words and one done pulse
   task automatic t_dma;
      int n, irq, w;
      cfg[0] <= mk(1'b1, 1'b0, 1'b1, 1'b1, 16'h0002);
      dsel[0] <= 7'h01;
      desc[0] <= '{count:16'h0002, irq_en:1'b1};
      page <= 16'h0001;
      dv[0] <= 1'b1;
      @(posedge sys_clk_i);
      dv[0] <= 1'b0;
      repeat (40) @(posedge sys_clk_i);
      `CHK("dma_idle", 1'b0, busy[0])
      page <= 16'h0000;
      dv[0] <= 1'b1;
      @(posedge sys_clk_i);
      dv[0] <= 1'b0;
      irq = 0;
      n = 0;
      do begin @(posedge sys_clk_i); n++; irq += int'(done_irq[0]); end
      while ((n < 5 || desc_ready[0] !== 1'b1 || busy[0] !== 1'b0)
             && n < 3000);
      bound(n, 3000);
      repeat (30) begin @(posedge sys_clk_i); irq += int'(done_irq[0]); end
      `CHK("irqs", 1, irq)
      w = 0;
      while (rx_valid[0] === 1'b1 && w < 9)
      begin
         w++;
         rxr[0] <= 1'b1;
         @(posedge sys_clk_i);
         rxr[0] <= 1'b0;
         @(posedge sys_clk_i);
      end
      `CHK("words", 2, w)
      dsel[0] <= '0;
      $display("test dma done");
   endtask
   task automatic sbyte(input logic [7:0] b, output logic [7:0] g);
      g = '0;
      for (int i = 7; i >= 0; i--)
      begin
         mosii[1] <= b[i];
         repeat (4) @(posedge sys_clk_i);
         g = {g[6:0], miso[1]};
         scki[1] <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         scki[1] <= 1'b0;
      end
   endtask
   // clocks without select are ignored; empty slave replies zero
   task automatic t_slave;
      logic [7:0] g;
      int         n;
      cfg[1] <= mk(1'b0, 1'b0, 1'b0, 1'b0, 16'h0001);
      repeat (2) @(posedge sys_clk_i);
      sbyte(8'hC3, g);
      repeat (8) @(posedge sys_clk_i);
      `CHK("unselected", 1'b0, rx_valid[1])
      ssn[1] <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      sbyte(8'h96, g);
      repeat (4) @(posedge sys_clk_i);
      ssn[1] <= 1'b1;
      n = 0;
      while (rx_valid[1] !== 1'b1 && n < 50)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      bound(n, 50);
      `CHK("slave_rx", 8'h96, rx_data[1][7:0])
      `CHK("zero_word", 8'h00, g)
      rxr[1] <= 1'b1;
      txd[1] <= 16'h005A;
      txv[1] <= 1'b1;
      @(posedge sys_clk_i);
      rxr[1] <= 1'b0;
      txv[1] <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      ssn[1] <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      sbyte(8'h00, g);
      repeat (4) @(posedge sys_clk_i);
      ssn[1] <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      `CHK("slave_tx", 8'h5A, g)
      rxr[1] <= 1'b1;
      @(posedge sys_clk_i);
      rxr[1] <= 1'b0;
      $display("test slave done");
   endtask
   // main sequence
   initial
   begin
      do_reset(1'b1);
      t_strap;
      t_master(1'b0, 16'h0001, 16'h003C, 16'h00A5);
      t_master(1'b1, 16'h0003, 16'hB00F, 16'h7E81);
      t_dma;
      t_slave;
      report_and_stop;
   end
endmodule
